// ---- dma_cmd_defines.svh ----
// Constants for the control byte decoder: patterns, bit positions, command codes
`ifndef DMA_CMD_DEFINES_SVH
`define DMA_CMD_DEFINES_SVH

// ************************************************
// Group identification masks and patterns
// ************************************************
`define GRP4_MASK 8'h83
`define GRP4_PAT 8'h81
`define GRP5_MASK 8'hc7
`define GRP5_PAT 8'h82
`define GRP6_MASK 8'h83
`define GRP6_PAT 8'h83

// ************************************************
// Mode/interrupt base byte fields
// ************************************************
`define B4_MODE_HI 6
`define B4_MODE_LO 5
`define B4_INTCTL 4
`define B4_ADDR_HI 3
`define B4_ADDR_LO 2

// ************************************************
// Interrupt control byte fields
// ************************************************
`define IC_MATCH 0
`define IC_EOB 1
`define IC_PULSE_A 2
`define IC_PULSE_B 3
`define IC_VECTOR 4
`define IC_SAV 5
`define IC_READY 6
`define VEC_CAUSE_HI 2
`define VEC_CAUSE_LO 1

// ************************************************
// Block-end/wait/ready base byte fields
// ************************************************
`define B5_AUTO 5
`define B5_WAIT 4
`define B5_RDY_POL 3

// ************************************************
// Command codes
// ************************************************
`define CMD_RESET 8'hc3
`define CMD_RST_A 8'hc7
`define CMD_RST_B 8'hcb
`define CMD_LOAD 8'hcf
`define CMD_CONT 8'hd3
`define CMD_EN_INT 8'hab
`define CMD_EN_XFER 8'h87

// ************************************************
// Cause codes placed in vector bits 2:1
// ************************************************
`define CAUSE_READY 2'h0
`define CAUSE_MATCH 2'h1
`define CAUSE_EOB 2'h2
`define CAUSE_PULSE 2'h3

`endif

// ---- dma_cmd_pkg.sv ----
// Types shared by the control byte decoder files
package dma_cmd_pkg;
	// Follow-on byte sequencer states
	typedef enum logic [2:0] {
		SEQ_BASE = 3'b000,
		SEQ_ADDR_LO = 3'b001,
		SEQ_ADDR_HI = 3'b010,
		SEQ_INTCTL = 3'b011,
		SEQ_PULSE = 3'b100,
		SEQ_VECTOR = 3'b101
	} seq_state_t;
	// Transfer operating modes
	typedef enum logic [1:0] {
		MODE_BYTE = 2'b00,
		MODE_CONT = 2'b01,
		MODE_BURST = 2'b10,
		MODE_RSVD = 2'b11
	} op_mode_t;
endpackage

// ---- dma_ctrl_decoder.sv ----
// Control byte decoder for mode/interrupt, block-end/wait/ready and command groups
//
// Contract
// - Detect mode/interrupt base byte by bits 7,1,0
// - Base bits 6,5 select operating mode
// - Base bits 2,3 bring Port B address bytes
// - Pointer bits bring control, vector, pulse bytes
// - Control bits 0,1,6 choose interrupt causes
// - Interrupt needs logic enabled first
// - Release bus before raising interrupt request
// - Status-affects-vector replaces vector bits 2:1
// - Pulse interrupt when offset equals counter low
// - Detect block-end group base by five bits
// - Bit 5 chooses stop or auto restart
// - Bit 4 chooses chip enable or wait
// - Bit 3 sets ready input polarity
// - Bits 7,1,0 set decode a command
// - Commands other than enable-transfer stop requests
// - Reset command clears control state, keeps reads
// - C7 and CB reset port timing
// - Load copies addresses, clears count, unforces ready
// - Load fills source now, destination later
// - Continue clears count, keeps addresses
// - Enable-interrupts command turns interrupt logic on
// - Causes latch while interrupts are disabled
`timescale 1ns/10ps
`include "dma_cmd_defines.svh"
module dma_ctrl_decoder #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_stb, // Control byte write strobe
	input wire logic [7:0] wr_data, // Control byte
	input wire logic ce_wait_n, // Chip-enable/wait pin
	input wire logic rdy, // Ready pin
	input wire logic bus_master, // Device holds the bus
	input wire logic match_event, // Byte match pulse from datapath
	input wire logic eob_event, // End-of-block pulse from datapath
	input wire logic count_tick, // Byte counter advance pulse
	input wire logic dst_first_count, // First destination count pulse
	input wire logic dst_fixed, // Destination address is fixed
	input wire logic src_is_a, // Port A is the source
	input wire logic match_int_en_grp, // Match group enables interrupts
	input wire logic iack, // Interrupt acknowledge
	input wire logic [ADDR_W-1:0] port_a_start, // Port A start address
	output logic [1:0] op_mode, // Operating mode
	output logic xfer_enabled, // Bus requesting allowed
	output logic bus_req, // Bus request
	output logic int_n, // Interrupt request, active low
	output logic [7:0] vector_out, // Vector placed on data bus
	output logic vector_oe, // Vector drive enable
	output logic wait_active, // Wait state inserted
	output logic auto_restart, // Auto restart selected
	output logic eob_status_clr, // End-of-block status clear pulse
	output logic force_ready_clr, // Force ready cancel pulse
	output logic port_a_std_timing, // Port A uses standard timing
	output logic port_b_std_timing, // Port B uses standard timing
	output logic [ADDR_W-1:0] src_addr_cnt, // Source address counter
	output logic [ADDR_W-1:0] dst_addr_cnt, // Destination address counter
	output logic [15:0] byte_cnt // Byte counter
);
	// ************************************************
	// Registers
	// ************************************************
	dma_cmd_pkg::seq_state_t seq_reg; // Follow-on sequencer
	logic [7:0] base4_reg; // Mode/interrupt base byte
	logic [7:0] intctl_reg; // Interrupt control byte
	logic [7:0] vector_reg; // Stored vector
	logic [7:0] pulse_reg; // Pulse offset byte
	logic [ADDR_W-1:0] pb_start_reg; // Port B start address
	logic [7:0] base5_reg; // Block-end/wait/ready byte
	logic xfer_en_reg; // Bus requesting enabled
	logic int_en_reg; // Interrupt logic enabled
	logic dst_pending_reg; // Destination load awaits first count
	logic [1:0] rdy_sync; // Ready synchroniser
	logic [1:0] cew_sync; // Chip-enable/wait synchroniser
	logic rdy_prev_reg; // Previous active ready
	logic pulse_ev; // Pulse match event
	logic vec_oe_reg; // Vector drive
	logic [7:0] vec_out_reg; // Vector output
	logic eob_clr_reg; // End-of-block clear pulse
	logic fr_clr_reg; // Force ready clear pulse
	logic pa_std_reg; // Port A standard timing
	logic pb_std_reg; // Port B standard timing
	logic [ADDR_W-1:0] src_reg; // Source counter
	logic [ADDR_W-1:0] dst_reg; // Destination counter
	logic [15:0] cnt_reg; // Byte counter
	logic at_base; // Sequencer expects a base byte
	logic is_grp4; // Mode/interrupt base byte
	logic is_grp5; // Block-end base byte
	logic is_cmd; // Command byte
	logic rdy_act; // Ready active after polarity
	logic int_req;
	logic [1:0] int_cause;

	int_pend_if ip ();

	// ************************************************
	// Byte classification
	// ************************************************
	assign at_base = (seq_reg == dma_cmd_pkg::SEQ_BASE);
	assign is_grp4 = at_base && wr_stb && ((wr_data & `GRP4_MASK) == `GRP4_PAT);
	assign is_grp5 = at_base && wr_stb && ((wr_data & `GRP5_MASK) == `GRP5_PAT);
	assign is_cmd = at_base && wr_stb && ((wr_data & `GRP6_MASK) == `GRP6_PAT);

	// Follow-on sequencer: next pointed byte in ascending order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg <= dma_cmd_pkg::SEQ_BASE;
		end else if (wr_stb) begin
			case (seq_reg)
				dma_cmd_pkg::SEQ_BASE: begin
					if (is_grp4 && wr_data[`B4_ADDR_LO] && wr_data[`B4_ADDR_HI]) begin
						seq_reg <= dma_cmd_pkg::SEQ_ADDR_LO;
					end else if (is_grp4 && wr_data[`B4_INTCTL]) begin
						seq_reg <= dma_cmd_pkg::SEQ_INTCTL;
					end
				end
				dma_cmd_pkg::SEQ_ADDR_LO: begin
					seq_reg <= dma_cmd_pkg::SEQ_ADDR_HI;
				end
				dma_cmd_pkg::SEQ_ADDR_HI: begin
					seq_reg <= base4_reg[`B4_INTCTL] ? dma_cmd_pkg::SEQ_INTCTL
						: dma_cmd_pkg::SEQ_BASE;
				end
				dma_cmd_pkg::SEQ_INTCTL: begin
					if (wr_data[`IC_PULSE_B]) begin
						seq_reg <= dma_cmd_pkg::SEQ_PULSE;
					end else if (wr_data[`IC_VECTOR]) begin
						seq_reg <= dma_cmd_pkg::SEQ_VECTOR;
					end else begin
						seq_reg <= dma_cmd_pkg::SEQ_BASE;
					end
				end
				dma_cmd_pkg::SEQ_PULSE: begin
					seq_reg <= intctl_reg[`IC_VECTOR] ? dma_cmd_pkg::SEQ_VECTOR
						: dma_cmd_pkg::SEQ_BASE;
				end
				default: begin
					seq_reg <= dma_cmd_pkg::SEQ_BASE;
				end
			endcase
		end
	end

	// ************************************************
	// Stored control bytes
	// ************************************************
	// Mode/interrupt base and its follow-on bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base4_reg <= 8'h00;
			intctl_reg <= 8'h00;
			pulse_reg <= 8'h00;
			vector_reg <= 8'h00;
			pb_start_reg <= '0;
		end else if (wr_stb) begin
			case (seq_reg)
				dma_cmd_pkg::SEQ_BASE: begin
					if (is_grp4) begin
						base4_reg <= wr_data;
					end
				end
				dma_cmd_pkg::SEQ_ADDR_LO: begin
					pb_start_reg[7:0] <= wr_data;
				end
				dma_cmd_pkg::SEQ_ADDR_HI: begin
					pb_start_reg[ADDR_W-1:8] <= wr_data[ADDR_W-9:0];
				end
				dma_cmd_pkg::SEQ_INTCTL: begin
					intctl_reg <= wr_data;
				end
				dma_cmd_pkg::SEQ_PULSE: begin
					pulse_reg <= wr_data;
				end
				dma_cmd_pkg::SEQ_VECTOR: begin
					vector_reg <= wr_data;
				end
				default: begin
					base4_reg <= base4_reg;
				end
			endcase
		end
	end

	// Block-end/wait/ready byte; reset command clears auto repeat and wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			base5_reg <= 8'h00;
		end else if (is_grp5) begin
			base5_reg <= wr_data;
		end else if (is_cmd && wr_data == `CMD_RESET) begin
			base5_reg[`B5_AUTO] <= 1'b0;
			base5_reg[`B5_WAIT] <= 1'b0;
		end
	end

	// ************************************************
	// Command execution
	// ************************************************
	// Bus requesting: only enable-transfer allows it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_en_reg <= 1'b0;
		end else if (is_cmd) begin
			xfer_en_reg <= (wr_data == `CMD_EN_XFER);
		end else if (int_req || (ip.cause_set != 4'h0 && int_en_reg)) begin
			xfer_en_reg <= 1'b0;
		end
	end

	// Interrupt logic enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_en_reg <= 1'b0;
		end else if (is_cmd && wr_data == `CMD_RESET) begin
			int_en_reg <= 1'b0;
		end else if ((is_cmd && wr_data == `CMD_EN_INT) || match_int_en_grp) begin
			int_en_reg <= 1'b1;
		end
	end

	// Port timing resets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_std_reg <= 1'b1;
			pb_std_reg <= 1'b1;
		end else if (is_cmd) begin
			pa_std_reg <= pa_std_reg | (wr_data == `CMD_RESET) | (wr_data == `CMD_RST_A);
			pb_std_reg <= pb_std_reg | (wr_data == `CMD_RESET) | (wr_data == `CMD_RST_B);
		end
	end

	// Force ready and end-of-block status clear pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fr_clr_reg <= 1'b0;
			eob_clr_reg <= 1'b0;
		end else begin
			fr_clr_reg <= is_cmd && (wr_data == `CMD_RESET || wr_data == `CMD_LOAD);
			eob_clr_reg <= eob_event && base5_reg[`B5_AUTO];
		end
	end

	// Address counters: source now, destination at first count unless fixed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_reg <= '0;
			dst_reg <= '0;
			dst_pending_reg <= 1'b0;
		end else if (is_cmd && wr_data == `CMD_LOAD) begin
			src_reg <= src_is_a ? port_a_start : pb_start_reg;
			dst_pending_reg <= !dst_fixed;
		end else if (dst_first_count && dst_pending_reg) begin
			dst_reg <= src_is_a ? pb_start_reg : port_a_start;
			dst_pending_reg <= 1'b0;
		end
	end

	// Byte counter; load and continue clear it, continue keeps addresses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
		end else if (is_cmd && (wr_data == `CMD_LOAD || wr_data == `CMD_CONT)) begin
			cnt_reg <= 16'h0000;
		end else if (eob_event && base5_reg[`B5_AUTO]) begin
			cnt_reg <= 16'h0000;
		end else if (count_tick) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// ************************************************
	// Pin synchronisers and interrupt causes
	// ************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_sync <= 2'b00;
			cew_sync <= 2'b11;
			// Matches the active-low ready seen after reset, so no false edge follows
			rdy_prev_reg <= 1'b1;
		end else begin
			rdy_sync <= {rdy_sync[0], rdy};
			cew_sync <= {cew_sync[0], ce_wait_n};
			rdy_prev_reg <= rdy_act;
		end
	end

	assign rdy_act = base5_reg[`B5_RDY_POL] ? rdy_sync[1] : !rdy_sync[1];
	assign pulse_ev = count_tick && intctl_reg[`IC_PULSE_A] && intctl_reg[`IC_PULSE_B]
		&& (cnt_reg[7:0] + 8'h01 == pulse_reg);

	assign ip.int_en = int_en_reg;
	assign ip.clear = is_cmd && wr_data == `CMD_RESET;
	assign ip.bus_released = !bus_master;
	assign ip.cause_set = {pulse_ev,
		eob_event && intctl_reg[`IC_EOB],
		match_event && intctl_reg[`IC_MATCH],
		rdy_act && !rdy_prev_reg && intctl_reg[`IC_READY]};
	assign int_req = ip.int_req;
	assign int_cause = ip.cause;

	int_latch u_int_latch (
		.clk(clk),
		.rst_n(rst_n),
		.ip(ip)
	);

	// Vector onto data bus during acknowledge, cause folded in when status-affects-vector is set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vec_out_reg <= 8'h00;
			vec_oe_reg <= 1'b0;
		end else begin
			vec_oe_reg <= iack && int_req;
			vec_out_reg <= intctl_reg[`IC_SAV]
				? {vector_reg[7:3], int_cause, vector_reg[0]} : vector_reg;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign op_mode = base4_reg[`B4_MODE_HI:`B4_MODE_LO];
	assign xfer_enabled = xfer_en_reg;
	assign bus_req = xfer_en_reg && rdy_act && !int_req;
	assign int_n = !int_req;
	assign vector_out = vec_out_reg;
	assign vector_oe = vec_oe_reg;
	assign wait_active = bus_master && base5_reg[`B5_WAIT] && !cew_sync[1];
	assign auto_restart = base5_reg[`B5_AUTO];
	assign eob_status_clr = eob_clr_reg;
	assign force_ready_clr = fr_clr_reg;
	assign port_a_std_timing = pa_std_reg;
	assign port_b_std_timing = pb_std_reg;
	assign src_addr_cnt = src_reg;
	assign dst_addr_cnt = dst_reg;
	assign byte_cnt = cnt_reg;

	// ************************************************
	// Assertions
	// ************************************************
	sequence s_addr_bytes;
		wr_stb && seq_reg == dma_cmd_pkg::SEQ_ADDR_LO;
	endsequence
	a_portb_addr_seq: assert property (@(posedge clk) disable iff (!rst_n)
		(is_grp4 && wr_data[`B4_ADDR_LO] && wr_data[`B4_ADDR_HI]) |=> s_addr_bytes or
		(seq_reg == dma_cmd_pkg::SEQ_ADDR_LO))
		else $error("port B address bytes not expected");
	a_cmd_stops_req: assert property (@(posedge clk) disable iff (!rst_n)
		(is_cmd && wr_data != `CMD_EN_XFER) |=> !bus_req)
		else $error("bus request after disabling command");
	a_continue_keeps: assert property (@(posedge clk) disable iff (!rst_n)
		(is_cmd && wr_data == `CMD_CONT) |=> cnt_reg == 16'h0000 && $stable(src_reg))
		else $error("continue did not clear count or moved address");
	a_reset_cmd_clr: assert property (@(posedge clk) disable iff (!rst_n)
		(is_cmd && wr_data == `CMD_RESET) |=> !int_en_reg && !auto_restart
		&& pa_std_reg && pb_std_reg)
		else $error("reset command left state set");
	a_mode_field: assert property (@(posedge clk) disable iff (!rst_n)
		is_grp4 |=> op_mode == $past(wr_data[`B4_MODE_HI:`B4_MODE_LO]))
		else $error("operating mode not taken from base byte");
	a_int_after_rel: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(int_req) |-> $past(!bus_master))
		else $error("interrupt raised while bus held");
	a_load_src_now: assert property (@(posedge clk) disable iff (!rst_n)
		(is_cmd && wr_data == `CMD_LOAD && !src_is_a) |=> src_reg == $past(pb_start_reg))
		else $error("source counter not loaded");
	a_rdy_polarity: assert property (@(posedge clk) disable iff (!rst_n)
		rdy_act == (base5_reg[`B5_RDY_POL] == rdy_sync[1]))
		else $error("ready polarity wrong");
endmodule

// ---- host_model.sv ----
// Host processor model that writes control bytes to the decoder
`timescale 1ns/10ps
`include "dma_cmd_defines.svh"
module host_model (
	input wire logic clk,
	output logic wr_stb,
	output logic [7:0] wr_data
);
	// Bus idle at time zero
	initial begin
		wr_stb = 1'b0;
		wr_data = 8'h00;
	end
	// One byte is taken per edge; the strobe stays up for back-to-back bytes
	task automatic put(input logic [7:0] b);
		@(posedge clk);
		#1;
		wr_stb = 1'b1;
		wr_data = b;
	endtask
	// Release the bus; stale data is inverted so it never looks valid
	task automatic idle();
		@(posedge clk);
		#1;
		wr_stb = 1'b0;
		wr_data = ~wr_data;
	endtask
	// Controller may be inactive, so another command goes first
	task automatic restart(input logic [7:0] cmd);
		put(`CMD_RST_A);
		put(cmd);
		idle();
	endtask
endmodule

// ---- int_latch.sv ----
// Interrupt cause latches and request sequencing
`timescale 1ns/10ps
`include "dma_cmd_defines.svh"
module int_latch (
	input wire logic clk,
	input wire logic rst_n,
	int_pend_if.seq ip
);
	logic [3:0] pend_reg; // Latched causes
	logic [1:0] cause_reg; // Cause of highest pending
	logic req_reg; // Request to processor

	// ************************************************
	// Cause latches: set wins over clear
	// ************************************************
	// Causes latch even while interrupt logic is disabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 4'h0;
		end else begin
			pend_reg <= (ip.clear ? 4'h0 : pend_reg) | ip.cause_set;
		end
	end

	// Cause selection, match before end-of-block before pulse before ready
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_reg <= `CAUSE_READY;
		end else if (pend_reg[1]) begin
			cause_reg <= `CAUSE_MATCH;
		end else if (pend_reg[2]) begin
			cause_reg <= `CAUSE_EOB;
		end else if (pend_reg[3]) begin
			cause_reg <= `CAUSE_PULSE;
		end else begin
			cause_reg <= `CAUSE_READY;
		end
	end

	// Request only when enabled and the bus is already released
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_reg <= 1'b0;
		end else begin
			req_reg <= ip.int_en && ip.bus_released && (pend_reg != 4'h0) && !ip.clear;
		end
	end

	assign ip.cause = cause_reg;
	assign ip.int_req = req_reg;

	a_req_needs_enable: assert property (@(posedge clk) disable iff (!rst_n)
		req_reg |-> $past(ip.int_en) && $past(ip.bus_released))
		else $error("interrupt request without enable or with bus held");
	a_latch_holds_off: assert property (@(posedge clk) disable iff (!rst_n)
		(ip.cause_set[1] && !ip.int_en) |=> pend_reg[1])
		else $error("match cause lost while interrupts disabled");
endmodule

// ---- int_pend_if.sv ----
// Interrupt pending signals between decoder and interrupt sequencer
`timescale 1ns/10ps
interface int_pend_if;
	logic int_en; // Interrupt logic enabled
	logic clear; // Clear latches
	logic [3:0] cause_set; // Cause events: ready, match, eob, pulse
	logic bus_released; // Device is off the bus
	logic [1:0] cause; // Cause of pending interrupt
	logic int_req; // Interrupt request
	modport ctl (output int_en, output clear, output cause_set, output bus_released,
		input cause, input int_req);
	modport seq (input int_en, input clear, input cause_set, input bus_released,
		output cause, output int_req);
endinterface

// ---- testbench.sv ----
// Self-checking bench for the control byte decoder
`timescale 1ns/10ps
`include "dma_cmd_defines.svh"
module testbench;
	// Design inputs
	logic clk, rst_n, ce_wait_n, rdy, bus_master, match_event, eob_event;
	logic count_tick, dst_first_count, dst_fixed, src_is_a, match_int_en_grp, iack;
	logic wr_stb;
	logic [7:0] wr_data;
	logic [15:0] pa_start; // Port A start address driven to the design
	// Design outputs
	logic [1:0] op_mode;
	logic xfer_enabled, bus_req, int_n, vector_oe, wait_active, auto_restart;
	logic eob_status_clr, force_ready_clr, port_a_std_timing, port_b_std_timing;
	logic [7:0] vector_out;
	logic [15:0] src_addr_cnt, dst_addr_cnt, byte_cnt;
	int n_mismatch = 0; // Mismatch count
	int total_checks = 0; // Comparison count
	int n_frc = 0; // Force-ready cancel pulses seen
	int cycles = 0; // Timeout counter

	host_model host_u (.clk(clk), .wr_stb(wr_stb), .wr_data(wr_data));
	dma_ctrl_decoder #(.ADDR_W(16)) dut_u (.clk(clk), .rst_n(rst_n), .wr_stb(wr_stb),
		.wr_data(wr_data), .ce_wait_n(ce_wait_n), .rdy(rdy), .bus_master(bus_master),
		.match_event(match_event), .eob_event(eob_event), .count_tick(count_tick),
		.dst_first_count(dst_first_count), .dst_fixed(dst_fixed), .src_is_a(src_is_a),
		.match_int_en_grp(match_int_en_grp), .iack(iack), .port_a_start(pa_start),
		.op_mode(op_mode), .xfer_enabled(xfer_enabled), .bus_req(bus_req), .int_n(int_n),
		.vector_out(vector_out), .vector_oe(vector_oe), .wait_active(wait_active),
		.auto_restart(auto_restart), .eob_status_clr(eob_status_clr),
		.force_ready_clr(force_ready_clr), .port_a_std_timing(port_a_std_timing),
		.port_b_std_timing(port_b_std_timing), .src_addr_cnt(src_addr_cnt),
		.dst_addr_cnt(dst_addr_cnt), .byte_cnt(byte_cnt));

	// ****************
	// Clock, monitors
	// ****************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Count cancel pulses and cut a hang short
	always @(posedge clk) begin
		if (force_ready_clr === 1'b1) n_frc++;
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// Compare and report
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Let n edges pass, then move off the edge
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Single-cycle pulse, then one idle edge so repeats never re-drive in one step
	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		chk("std_a", port_a_std_timing, 1);
		chk("std_b", port_b_std_timing, 1);
		chk("int_n", int_n, 1);
		chk("xfer", xfer_enabled, 0);
		$display("test reset done");
	endtask
	// Burst mode, address bytes back to back, a command-looking byte as low byte
	task automatic t_addr_load();
		int f;
		host_u.put(8'hcd);
		host_u.put(8'hcf);
		host_u.put(8'h12);
		host_u.idle();
		step(2);
		chk("op_mode", op_mode, 2'b10);
		chk("src_before", src_addr_cnt, 16'h0000);
		repeat (3) pulse(count_tick);
		step(1);
		chk("cnt3", byte_cnt, 16'h0003);
		f = n_frc;
		host_u.restart(`CMD_LOAD);
		step(2);
		chk("src", src_addr_cnt, 16'h12cf);
		chk("dst_wait", dst_addr_cnt, 16'h0000);
		chk("cnt0", byte_cnt, 16'h0000);
		chk("frc", n_frc - f, 1);
		pulse(dst_first_count);
		step(1);
		chk("dst", dst_addr_cnt, 16'hbeef);
		repeat (2) pulse(count_tick);
		host_u.restart(`CMD_CONT);
		step(2);
		chk("cont_cnt", byte_cnt, 16'h0000);
		chk("cont_src", src_addr_cnt, 16'h12cf);
		$display("test address load done");
	endtask
	// Auto restart, wait use, ready polarity and request gating
	task automatic t_block_end();
		host_u.put(8'hba);
		host_u.idle();
		bus_master = 1'b1;
		ce_wait_n = 1'b0;
		step(4);
		chk("auto", auto_restart, 1);
		chk("wait_on", wait_active, 1);
		bus_master = 1'b0;
		step(1);
		chk("wait_off", wait_active, 0);
		rdy = 1'b1;
		host_u.put(`CMD_EN_XFER);
		host_u.idle();
		step(4);
		chk("xfer_on", xfer_enabled, 1);
		chk("req_hi", bus_req, 1);
		host_u.put(8'h82);
		host_u.idle();
		step(4);
		chk("req_pol", bus_req, 0);
		chk("auto_off", auto_restart, 0);
		host_u.put(`CMD_RST_B);
		host_u.idle();
		step(2);
		chk("xfer_off", xfer_enabled, 0);
		chk("std_b2", port_b_std_timing, 1);
		host_u.put(8'hba);
		host_u.put(`CMD_RESET);
		host_u.idle();
		bus_master = 1'b1;
		step(4);
		chk("rst_auto", auto_restart, 0);
		chk("rst_wait", wait_active, 0);
		bus_master = 1'b0;
		ce_wait_n = 1'b1;
		$display("test block end done");
	endtask
	// Match interrupt: latched while disabled, held off while on the bus
	task automatic t_interrupt();
		// Auto restart is off here, so a cause-modified vector is allowed
		host_u.put(8'h91);
		host_u.put(8'h31);
		host_u.put(8'h40);
		host_u.idle();
		pulse(match_event);
		step(6);
		chk("int_dis", int_n, 1);
		bus_master = 1'b1;
		host_u.put(`CMD_EN_INT);
		host_u.idle();
		step(8);
		chk("int_bus", int_n, 1);
		bus_master = 1'b0;
		for (int i = 0; i < 20 && int_n !== 1'b0; i++) step(1);
		chk("int_on", int_n, 0);
		iack = 1'b1;
		step(3);
		chk("vec", vector_out, 8'h42);
		chk("vec_oe", vector_oe, 1);
		iack = 1'b0;
		host_u.put(`CMD_RESET);
		host_u.idle();
		step(3);
		chk("int_clr", int_n, 1);
		pulse(match_event);
		pulse(match_int_en_grp);
		for (int i = 0; i < 20 && int_n !== 1'b0; i++) step(1);
		chk("int_grp", int_n, 0);
		$display("test interrupt done");
	endtask
	// Port A source, fixed destination, auto restart and pulse interrupt
	task automatic t_src_a();
		pa_start = 16'h3a5c;
		src_is_a = 1'b1;
		dst_fixed = 1'b1;
		host_u.put(`CMD_RESET);
		host_u.put(8'hba);
		host_u.put(`CMD_LOAD);
		host_u.idle();
		step(2);
		chk("src_a", src_addr_cnt, 16'h3a5c);
		pulse(dst_first_count);
		chk("dst_fixed", dst_addr_cnt, 16'hbeef);
		pulse(count_tick);
		eob_event = 1'b1;
		step(1);
		eob_event = 1'b0;
		chk("eob_clr", eob_status_clr, 1);
		chk("eob_cnt", byte_cnt, 16'h0000);
		step(1);
		chk("eob_clr_end", eob_status_clr, 0);
		host_u.put(8'h91);
		host_u.put(8'h0c);
		host_u.put(8'h02);
		host_u.put(`CMD_EN_INT);
		host_u.idle();
		pulse(count_tick);
		chk("pulse_early", int_n, 1);
		pulse(count_tick);
		step(1);
		chk("pulse_int", int_n, 0);
		$display("test port a source done");
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Main sequence
	initial begin
		ce_wait_n = 1'b1;
		rdy = 1'b0;
		bus_master = 1'b0;
		match_event = 1'b0;
		eob_event = 1'b0;
		count_tick = 1'b0;
		dst_first_count = 1'b0;
		dst_fixed = 1'b0;
		src_is_a = 1'b0;
		match_int_en_grp = 1'b0;
		iack = 1'b0;
		pa_start = 16'hbeef;
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		t_reset();
		t_addr_load();
		t_block_end();
		t_interrupt();
		t_src_a();
		complete_run();
	end
endmodule
